// File: include/adc_seq_pkg.sv
// Constants, register map and types for the converter sequence control block.
package adc_seq_pkg;

	// ---------------------------------------------------------------
	// Register port
	// ---------------------------------------------------------------
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	localparam logic [3:0] REG_REF    = 4'h0;
	localparam logic [3:0] REG_PCH    = 4'h1;
	localparam logic [3:0] REG_PRE    = 4'h2;
	localparam logic [3:0] REG_ACQ    = 4'h3;
	localparam logic [3:0] REG_CAP    = 4'h4;
	localparam logic [3:0] REG_RPT    = 4'h5;
	localparam logic [3:0] REG_CNT    = 4'h6;
	localparam logic [3:0] REG_FLTH   = 4'h7;
	localparam logic [3:0] REG_FLTL   = 4'h8;
	localparam logic [3:0] REG_CTRL   = 4'h9;
	localparam logic [3:0] REG_CLKDIV = 4'hA;
	localparam logic [3:0] REG_MODE   = 4'hB;
	localparam logic [3:0] REG_STATUS = 4'hC;

	// Writable bit masks; bits outside them read zero.
	localparam logic [7:0] REF_MASK    = 8'h13;
	localparam logic [7:0] PCH_MASK    = 8'h3F;
	localparam logic [7:0] CAP_MASK    = 8'h1F;
	localparam logic [7:0] CTRL_MASK   = 8'h01;
	localparam logic [7:0] CLKDIV_MASK = 8'h3F;
	localparam logic [7:0] MODE_MASK   = 8'h77;
	localparam logic [7:0] CFG_RESET   = 8'h00;

	// ---------------------------------------------------------------
	// Fields
	// ---------------------------------------------------------------
	localparam int NEG_REF_BIT = 4;
	localparam int CLK_SRC_BIT = 0;
	localparam int MODE_LSB    = 0;
	localparam int SHIFT_LSB   = 4;

	localparam logic [1:0] POS_REF_VDD = 2'h0;
	localparam logic [1:0] POS_REF_PIN = 2'h2;
	localparam logic [1:0] POS_REF_FIXED = 2'h3;

	localparam logic [5:0] CH_FIXED    = 6'h3F;
	localparam logic [5:0] CH_DAC      = 6'h3E;
	localparam logic [5:0] CH_TEMP     = 6'h3D;
	localparam logic [5:0] CH_GND      = 6'h3C;
	localparam logic [5:0] CH_PIN_LAST = 6'h22;

	localparam logic [2:0] MODE_ACCUM = 3'h1;
	localparam logic [2:0] MODE_AVG   = 3'h2;
	localparam logic [2:0] MODE_BURST = 3'h3;
	localparam logic [2:0] MODE_LOWPASS = 3'h4;

	// ---------------------------------------------------------------
	// Counts
	// ---------------------------------------------------------------
	localparam logic [7:0] CNT_MAX        = 8'hFF;
	localparam logic [8:0] ACQ_LONG_TICKS = 9'h100;
	localparam logic [8:0] CONV_TICKS     = 9'h00B;

	typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_ACQ, ST_CONV} seq_state_e;

endpackage : adc_seq_pkg

// File: rtl/conv_tick_gen.sv
// Converter clock enable generator: one tick per converter clock period.
`timescale 1ns/1ps
module conv_tick_gen
	import adc_seq_pkg::*;
(
	// Clock and reset
	input  wire logic       i_clk,
	input  wire logic       i_rst,
	// Selection
	input  wire logic       i_use_divider,
	input  wire logic [5:0] i_div_code,
	// Tick
	output logic            o_tick
);

	logic [6:0] cnt_reg;
	logic [6:0] last_count;
	logic       wrap;

	// Ratio is 2*(code+1), so the count runs 0 .. 2*code+1.
	assign last_count = {i_div_code, 1'b1};
	assign wrap       = (cnt_reg >= last_count);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt_reg <= 7'h00;
			o_tick  <= 1'b0;
		end else begin
			cnt_reg <= (wrap || !i_use_divider) ? 7'h00 : cnt_reg + 7'h01;
			o_tick  <= !i_use_divider || wrap;
		end
	end

endmodule : conv_tick_gen

// File: rtl/adc_sequence_config.sv
// Converter configuration registers, stage sequencer and filter output.
`timescale 1ns/1ps

module adc_sequence_config
	import adc_seq_pkg::*;
(
	// Clock and reset
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	// Register port
	input  wire logic [3:0]  i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	// Conversion engine
	input  wire logic        i_trigger,
	input  wire logic [15:0] i_accumulator_value,
	input  wire logic [15:0] i_lowpass_value,
	// Analog controls
	output logic             o_neg_ref_pin,
	output logic             o_pos_ref_vdd,
	output logic             o_pos_ref_pin,
	output logic             o_pos_ref_fixed,
	output logic             o_channel_connect,
	output logic      [5:0]  o_channel_pin,
	output logic             o_channel_is_pin,
	output logic             o_channel_fixed,
	output logic             o_channel_dac,
	output logic             o_channel_temp,
	output logic             o_channel_gnd,
	output logic      [4:0]  o_extra_sample_cap,
	// Sequencer
	output logic             o_precharge,
	output logic             o_acquire,
	output logic             o_converting,
	output logic             o_threshold_check,
	output logic      [15:0] o_filter_output
);

	// ---------------------------------------------------------------
	// Registers
	// ---------------------------------------------------------------
	logic [7:0] ref_reg, pch_reg, pre_reg, acq_reg, cap_reg, rpt_reg;
	logic [7:0] cnt_reg, ctrl_reg, clkdiv_reg, mode_reg;
	logic [7:0] cnt_next;

	logic       wr_ref, wr_pch, wr_pre, wr_acq, wr_cap, wr_rpt;
	logic       wr_cnt, wr_ctrl, wr_clkdiv, wr_mode;

	assign wr_ref    = i_wr && (i_addr == REG_REF);
	assign wr_pch    = i_wr && (i_addr == REG_PCH);
	assign wr_pre    = i_wr && (i_addr == REG_PRE);
	assign wr_acq    = i_wr && (i_addr == REG_ACQ);
	assign wr_cap    = i_wr && (i_addr == REG_CAP);
	assign wr_rpt    = i_wr && (i_addr == REG_RPT);
	assign wr_cnt    = i_wr && (i_addr == REG_CNT);
	assign wr_ctrl   = i_wr && (i_addr == REG_CTRL);
	assign wr_clkdiv = i_wr && (i_addr == REG_CLKDIV);
	assign wr_mode   = i_wr && (i_addr == REG_MODE);

	seq_state_e state_reg, state_next;
	logic       start;
	logic [2:0] mode;
	logic [2:0] shift;

	assign start = i_trigger && (state_reg == ST_IDLE);
	assign mode  = mode_reg[MODE_LSB +: 3];
	assign shift = mode_reg[SHIFT_LSB +: 3];

	// A start (trigger while idle) in the same cycle as a software write wins, so
	// no count is lost to the write; counts past CNT_MAX are lost to saturation.
	assign cnt_next = start ? ((cnt_reg == CNT_MAX) ? CNT_MAX
	                                  : cnt_reg + 8'h01)
	                        : (wr_cnt ? i_wdata : cnt_reg);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			ref_reg    <= CFG_RESET;
			pch_reg    <= CFG_RESET;
			pre_reg    <= CFG_RESET;
			acq_reg    <= CFG_RESET;
			cap_reg    <= CFG_RESET;
			rpt_reg    <= CFG_RESET;
			cnt_reg    <= CFG_RESET;
			ctrl_reg   <= CFG_RESET;
			clkdiv_reg <= CFG_RESET;
			mode_reg   <= CFG_RESET;
		end else begin
			if (wr_ref)    ref_reg    <= i_wdata & REF_MASK;
			if (wr_pch)    pch_reg    <= i_wdata & PCH_MASK;
			if (wr_pre)    pre_reg    <= i_wdata;
			if (wr_acq)    acq_reg    <= i_wdata;
			if (wr_cap)    cap_reg    <= i_wdata & CAP_MASK;
			if (wr_rpt)    rpt_reg    <= i_wdata;
			if (wr_ctrl)   ctrl_reg   <= i_wdata & CTRL_MASK;
			if (wr_clkdiv) clkdiv_reg <= i_wdata & CLKDIV_MASK;
			if (wr_mode)   mode_reg   <= i_wdata & MODE_MASK;
			cnt_reg <= cnt_next;
		end
	end

	// ---------------------------------------------------------------
	// Reference and channel routing
	// ---------------------------------------------------------------
	logic [1:0] pos_ref;
	logic [5:0] chan;
	logic       chan_is_pin;
	logic       chan_special;

	assign pos_ref      = ref_reg[1:0];
	assign chan         = pch_reg[5:0];
	assign chan_is_pin  = (chan <= CH_PIN_LAST);
	assign chan_special = (chan >= CH_GND);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_neg_ref_pin      <= 1'b0;
			o_pos_ref_vdd      <= 1'b0;
			o_pos_ref_pin      <= 1'b0;
			o_pos_ref_fixed    <= 1'b0;
			o_channel_connect  <= 1'b0;
			o_channel_pin      <= 6'h00;
			o_channel_is_pin   <= 1'b0;
			o_channel_fixed    <= 1'b0;
			o_channel_dac      <= 1'b0;
			o_channel_temp     <= 1'b0;
			o_channel_gnd      <= 1'b0;
			o_extra_sample_cap <= 5'h00;
		end else begin
			o_neg_ref_pin      <= ref_reg[NEG_REF_BIT];
			o_pos_ref_vdd      <= (pos_ref == POS_REF_VDD);
			o_pos_ref_pin      <= (pos_ref == POS_REF_PIN);
			o_pos_ref_fixed    <= (pos_ref == POS_REF_FIXED);
			o_channel_connect  <= chan_is_pin || chan_special;
			o_channel_pin      <= chan_is_pin ? chan : 6'h00;
			o_channel_is_pin   <= chan_is_pin;
			o_channel_fixed    <= (chan == CH_FIXED);
			o_channel_dac      <= (chan == CH_DAC);
			o_channel_temp     <= (chan == CH_TEMP);
			o_channel_gnd      <= (chan == CH_GND);
			o_extra_sample_cap <= cap_reg[4:0];
		end
	end

	// ---------------------------------------------------------------
	// Converter clock
	// ---------------------------------------------------------------
	logic tick;

	conv_tick_gen u_tick (
		.i_clk         (i_clk),
		.i_rst         (i_rst),
		.i_use_divider (ctrl_reg[CLK_SRC_BIT]),
		.i_div_code    (clkdiv_reg[5:0]),
		.o_tick        (tick)
	);

	// ---------------------------------------------------------------
	// Stage sequencer
	// ---------------------------------------------------------------
	logic [8:0] remain_reg, remain_next;
	logic [8:0] acq_ticks;
	logic       stage_end;
	logic       check_mode;

	// Zero acquisition after a precharge still needs charge sharing.
	assign acq_ticks  = (acq_reg == 8'h00) ? ACQ_LONG_TICKS
	                                       : {1'b0, acq_reg};
	assign stage_end  = tick && (remain_reg == 9'h001);
	assign check_mode = (mode == MODE_LOWPASS) || (mode == MODE_AVG)
	                 || (mode == MODE_BURST);

	always_comb begin
		state_next  = state_reg;
		remain_next = remain_reg;
		case (state_reg)
			ST_IDLE: begin
				if (start) begin
					if (pre_reg != 8'h00) begin
						state_next  = ST_PRE;
						remain_next = {1'b0, pre_reg};
					end else if (acq_reg != 8'h00) begin
						state_next  = ST_ACQ;
						remain_next = {1'b0, acq_reg};
					end else begin
						state_next  = ST_CONV;
						remain_next = CONV_TICKS;
					end
				end
			end
			ST_PRE: begin
				if (stage_end) begin
					state_next  = ST_ACQ;
					remain_next = acq_ticks;
				end else if (tick) begin
					remain_next = remain_reg - 9'h001;
				end
			end
			ST_ACQ: begin
				if (stage_end) begin
					state_next  = ST_CONV;
					remain_next = CONV_TICKS;
				end else if (tick) begin
					remain_next = remain_reg - 9'h001;
				end
			end
			ST_CONV: begin
				if (stage_end) begin
					state_next  = ST_IDLE;
					remain_next = 9'h000;
				end else if (tick) begin
					remain_next = remain_reg - 9'h001;
				end
			end
			default: begin
				state_next  = ST_IDLE;
				remain_next = 9'h000;
			end
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state_reg         <= ST_IDLE;
			remain_reg        <= 9'h000;
			o_precharge       <= 1'b0;
			o_acquire         <= 1'b0;
			o_converting      <= 1'b0;
			o_threshold_check <= 1'b0;
		end else begin
			state_reg         <= state_next;
			remain_reg        <= remain_next;
			o_precharge       <= (state_next == ST_PRE);
			o_acquire         <= (state_next == ST_ACQ);
			o_converting      <= (state_next == ST_CONV);
			o_threshold_check <= (state_reg == ST_CONV) && stage_end
			                  && check_mode && (cnt_reg >= rpt_reg);
		end
	end

	// ---------------------------------------------------------------
	// Filter output
	// ---------------------------------------------------------------
	logic        shift_mode;
	logic [15:0] shifted;

	// Arithmetic shift drops the low bits, so the quotient rounds toward minus infinity.
	assign shifted    = 16'($signed(i_accumulator_value) >>> shift);
	assign shift_mode = (mode == MODE_ACCUM) || (mode == MODE_AVG)
	                 || (mode == MODE_BURST);

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_filter_output <= 16'h0000;
		end else if (shift_mode) begin
			o_filter_output <= shifted;
		end else if (mode == MODE_LOWPASS) begin
			o_filter_output <= i_lowpass_value;
		end
	end

	// ---------------------------------------------------------------
	// Read port
	// ---------------------------------------------------------------
	logic [7:0] rd_mux;
	logic [7:0] status;

	assign status = {5'h00, o_converting, o_acquire, o_precharge};
	assign rd_mux =
		(i_addr == REG_REF)    ? ref_reg :
		(i_addr == REG_PCH)    ? pch_reg :
		(i_addr == REG_PRE)    ? pre_reg :
		(i_addr == REG_ACQ)    ? acq_reg :
		(i_addr == REG_CAP)    ? cap_reg :
		(i_addr == REG_RPT)    ? rpt_reg :
		(i_addr == REG_CNT)    ? cnt_reg :
		(i_addr == REG_FLTH)   ? o_filter_output[15:8] :
		(i_addr == REG_FLTL)   ? o_filter_output[7:0] :
		(i_addr == REG_CTRL)   ? ctrl_reg :
		(i_addr == REG_CLKDIV) ? clkdiv_reg :
		(i_addr == REG_MODE)   ? mode_reg :
		(i_addr == REG_STATUS) ? status : 8'h00;

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_rdata <= 8'h00;
		end else begin
			o_rdata <= i_rd ? rd_mux : 8'h00;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	logic [8:0] stage_ticks;

	always_ff @(posedge i_clk) begin
		if (i_rst || state_next != state_reg) begin
			stage_ticks <= 9'h000;
		end else if (tick) begin
			stage_ticks <= stage_ticks + 9'h001;
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_rst);

	sequence s_pre_exit;
		(state_reg == ST_PRE) && stage_end;
	endsequence

	sequence s_acq_exit;
		(state_reg == ST_ACQ) && stage_end;
	endsequence

	neg_ref_a: assert property (
		wr_ref |-> ##2 (o_neg_ref_pin == $past(i_wdata[NEG_REF_BIT], 2)))
		else $error("negative reference route wrong");

	pos_ref_a: assert property (
		$onehot0({o_pos_ref_vdd, o_pos_ref_pin, o_pos_ref_fixed})
		&& (o_pos_ref_fixed == ($past(pos_ref) == POS_REF_FIXED)))
		else $error("positive reference route wrong");

	chan_none_a: assert property (
		(wr_pch && i_wdata[5:0] == 6'h3B) |-> ##2 !o_channel_connect)
		else $error("reserved channel connected an input");

	pre_len_a: assert property (
		s_pre_exit |-> (stage_ticks + 9'h001 == {1'b0, pre_reg}))
		else $error("precharge length wrong");

	pre_skip_a: assert property (
		(start && pre_reg == 8'h00) |=> (state_reg != ST_PRE))
		else $error("zero precharge not skipped");

	acq_len_a: assert property (
		s_acq_exit |-> (stage_ticks + 9'h001 == acq_ticks))
		else $error("acquisition length wrong");

	acq_skip_a: assert property (
		(start && pre_reg == 8'h00 && acq_reg == 8'h00)
		|=> (state_reg == ST_CONV))
		else $error("zero acquisition not omitted");

	acq_long_a: assert property (
		(s_pre_exit ##0 (acq_reg == 8'h00 && state_next == ST_ACQ))
		|=> (remain_reg == ACQ_LONG_TICKS))
		else $error("long acquisition not loaded");

	undivided_a: assert property (
		(!ctrl_reg[CLK_SRC_BIT] && $past(!ctrl_reg[CLK_SRC_BIT])
		&& !$past(i_rst)) |-> tick)
		else $error("oscillator source not undivided");

	cnt_inc_a: assert property (
		(start && cnt_reg != CNT_MAX) |=> (cnt_reg == $past(cnt_reg) + 8'h01))
		else $error("trigger counter did not increment");

	cnt_sat_a: assert property (
		(start && cnt_reg == CNT_MAX) |=> (cnt_reg == CNT_MAX))
		else $error("trigger counter wrapped");

	thresh_a: assert property (
		o_threshold_check |-> ($past(check_mode)
		&& $past(cnt_reg) >= $past(rpt_reg) && state_reg == ST_IDLE))
		else $error("threshold check out of place");

	filt_shift_a: assert property (
		shift_mode |=> (o_filter_output == $past(shifted)))
		else $error("filter output not shifted accumulator");

	unimpl_a: assert property (
		(i_rd && i_addr == REG_REF) |=> (o_rdata[7:5] == 3'h0
		&& o_rdata[3:2] == 2'h0))
		else $error("unimplemented bits read nonzero");

	order_a: assert property (
		(state_reg == ST_PRE && state_next != ST_PRE) |-> state_next == ST_ACQ)
		else $error("stage order broken");

endmodule : adc_sequence_config

// File: test/tb.sv
// Self-checking testbench for the converter sequence control block.
`timescale 1ns/1ps
module tb
	import adc_seq_pkg::*;
;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic        i_clk, i_rst, i_wr, i_rd, i_trigger;
	logic [3:0]  i_addr;
	logic [7:0]  i_wdata, o_rdata;
	logic [15:0] i_accumulator_value, i_lowpass_value, o_filter_output;
	logic        o_neg_ref_pin, o_pos_ref_vdd, o_pos_ref_pin;
	logic        o_pos_ref_fixed, o_channel_connect, o_channel_is_pin;
	logic        o_channel_fixed, o_channel_dac, o_channel_temp;
	logic        o_channel_gnd;
	logic [5:0]  o_channel_pin;
	logic [4:0]  o_extra_sample_cap;
	logic        o_precharge, o_acquire, o_converting, o_threshold_check;
	int          mismatches = 0;
	int          checked = 0;

	adc_sequence_config i_dut (
		.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
		.i_trigger, .i_accumulator_value, .i_lowpass_value,
		.o_neg_ref_pin, .o_pos_ref_vdd, .o_pos_ref_pin, .o_pos_ref_fixed,
		.o_channel_connect, .o_channel_pin, .o_channel_is_pin,
		.o_channel_fixed, .o_channel_dac, .o_channel_temp, .o_channel_gnd,
		.o_extra_sample_cap, .o_precharge, .o_acquire, .o_converting,
		.o_threshold_check, .o_filter_output
	);

	always #4 i_clk = ~i_clk;

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic chk_rng(input int got, input int lo, input int hi);
		checked++;
		if (got < lo || got > hi) begin
			mismatches++;
			$display("BAD at %0t: got %h range %h %h", $time, got, lo, hi);
		end
	endtask : chk_rng

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge i_clk);
		i_addr <= a;
		i_wdata <= d;
		i_wr <= 1'b1;
		@(posedge i_clk);
		i_wr <= 1'b0;
	endtask : wr

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
		@(posedge i_clk);
		i_addr <= a;
		i_rd <= 1'b1;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		chk({8'h00, o_rdata}, {8'h00, exp});
	endtask : rd_chk

	task automatic settle;
		repeat (3) @(posedge i_clk);
		#1;
	endtask : settle

	// One trigger, with a second one thrown in while busy; stage cycles
	// are counted and the stage order is watched on every cycle.
	task automatic run_conv(output int np, output int na, output int nc,
			output logic thr, output logic bad);
		logic sa, sc;
		np = 0;
		na = 0;
		nc = 0;
		bad = 1'b0;
		sa = 1'b0;
		sc = 1'b0;
		thr = 1'b0;
		@(posedge i_clk);
		i_trigger <= 1'b1;
		@(posedge i_clk);
		i_trigger <= 1'b0;
		for (int n = 0; n < 4000; n++) begin
			#1;
			thr = o_threshold_check;
			if ($isunknown({o_precharge, o_acquire, o_converting}))
				bad = 1'b1;
			if (!(o_precharge || o_acquire || o_converting))
				break;
			if ($countones({o_precharge, o_acquire, o_converting}) > 1)
				bad = 1'b1;
			if ((o_precharge && (sa || sc)) || (o_acquire && sc))
				bad = 1'b1;
			sa = sa | o_acquire;
			sc = sc | o_converting;
			np += int'(o_precharge);
			na += int'(o_acquire);
			nc += int'(o_converting);
			@(posedge i_clk);
			i_trigger <= (n == 2);
		end
	endtask : run_conv

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic s_regs;
		logic [3:0] a[6] = '{REG_REF, REG_PCH, REG_PRE, REG_ACQ, REG_CAP,
			REG_RPT};
		logic [7:0] m[6] = '{8'h13, 8'h3F, 8'hFF, 8'hFF, 8'h1F, 8'hFF};
		for (int k = 0; k < 6; k++) begin
			rd_chk(a[k], 8'h00);
			wr(a[k], 8'hFF);
			rd_chk(a[k], m[k]);
			wr(a[k], 8'h00);
		end
		wr(4'hD, 8'hFF);
		rd_chk(4'hD, 8'h00);
		wr(REG_FLTH, 8'hFF);
		rd_chk(REG_FLTH, 8'h00);
	endtask : s_regs

	task automatic s_analog;
		logic [7:0] ch[9] = '{8'h3F, 8'h3E, 8'h3D, 8'h3C, 8'h3B, 8'h23,
			8'h22, 8'h05, 8'h00};
		logic [7:0] c;
		logic [2:0] pr;
		for (int k = 0; k < 8; k++) begin
			wr(REG_REF, {3'h0, k[2], 2'h0, k[1:0]});
			settle();
			pr = (k[1:0] == 2'h0) ? 3'h4 : (k[1:0] == 2'h2) ? 3'h2 :
				(k[1:0] == 2'h3) ? 3'h1 : 3'h0;
			chk({15'h0, o_neg_ref_pin}, {15'h0, k[2]});
			chk({13'h0, o_pos_ref_vdd, o_pos_ref_pin, o_pos_ref_fixed},
				{13'h0, pr});
		end
		for (int k = 0; k < 9; k++) begin
			c = ch[k];
			wr(REG_PCH, c);
			settle();
			chk({4'h0, o_channel_connect, o_channel_is_pin, o_channel_fixed,
				o_channel_dac, o_channel_temp, o_channel_gnd, o_channel_pin},
				{4'h0, c <= 8'h22 || c >= 8'h3C, c <= 8'h22, c == 8'h3F,
				c == 8'h3E, c == 8'h3D, c == 8'h3C,
				(c <= 8'h22) ? c[5:0] : 6'h00});
		end
		for (int k = 0; k < 32; k += 15) begin
			wr(REG_CAP, 8'(k + 1));
			settle();
			chk({11'h0, o_extra_sample_cap}, 16'(k + 1));
		end
	endtask : s_analog

	task automatic s_seq(input logic [7:0] div, input logic [7:0] pre,
			input logic [7:0] acq, input int r);
		int np, na, nc, ep, ea;
		logic thr, bad;
		wr(REG_CLKDIV, div);
		wr(REG_PRE, pre);
		wr(REG_ACQ, acq);
		run_conv(np, na, nc, thr, bad);
		ep = int'(pre);
		ea = (acq != 8'h00) ? int'(acq) : (pre != 8'h00) ? 256 : 0;
		chk_rng(np, (ep == 0) ? 0 : (ep - 1) * r + 1, ep * r);
		chk_rng(na, (ea == 0) ? 0 : (ea - 1) * r + 1, ea * r);
		chk_rng(nc, 10 * r + 1, 11 * r);
		chk({15'h0, bad}, 16'h0000);
	endtask : s_seq

	task automatic s_count;
		int np, na, nc;
		logic thr, bad;
		wr(REG_CNT, 8'h10);
		run_conv(np, na, nc, thr, bad);
		rd_chk(REG_CNT, 8'h11);
		wr(REG_CNT, 8'hFE);
		for (int k = 0; k < 2; k++) begin
			run_conv(np, na, nc, thr, bad);
			rd_chk(REG_CNT, 8'hFF);
		end
		wr(REG_PRE, 8'h20);
		@(posedge i_clk);
		i_trigger <= 1'b1;
		@(posedge i_clk);
		i_trigger <= 1'b0;
		rd_chk(REG_STATUS, 8'h01);
		repeat (60) @(posedge i_clk);
		rd_chk(REG_STATUS, 8'h00);
	endtask : s_count

	task automatic s_thresh;
		int np, na, nc;
		logic thr, bad;
		wr(REG_RPT, 8'h12);
		wr(REG_CNT, 8'h10);
		wr(REG_MODE, 8'h02);
		run_conv(np, na, nc, thr, bad);
		chk({15'h0, thr}, 16'h0000);
		for (int m = 0; m < 5; m++) begin
			wr(REG_MODE, 8'(m));
			run_conv(np, na, nc, thr, bad);
			chk({15'h0, thr}, {15'h0, m >= 2});
		end
	endtask : s_thresh

	task automatic s_filter;
		@(posedge i_clk);
		i_accumulator_value <= 16'h8007;
		i_lowpass_value <= 16'h5A3C;
		for (int m = 1; m < 4; m++) begin
			wr(REG_MODE, 8'h30 | 8'(m));
			settle();
			chk(o_filter_output, 16'hF000);
			rd_chk(REG_FLTH, 8'hF0);
			rd_chk(REG_FLTL, 8'h00);
		end
		@(posedge i_clk);
		i_accumulator_value <= 16'h1237;
		wr(REG_MODE, 8'h21);
		settle();
		chk(o_filter_output, 16'h048D);
		wr(REG_MODE, 8'h04);
		settle();
		rd_chk(REG_FLTH, 8'h5A);
		rd_chk(REG_FLTL, 8'h3C);
	endtask : s_filter

	// ---------------------------------------------------------------
	// Sequence and verdict
	// ---------------------------------------------------------------
	task automatic end_of_test;
		if (mismatches == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	initial begin
		i_clk = 1'b0;
		i_rst = 1'b1;
		i_addr = 4'h0;
		i_wdata = 8'h00;
		i_wr = 1'b0;
		i_rd = 1'b0;
		i_trigger = 1'b0;
		i_accumulator_value = 16'h0000;
		i_lowpass_value = 16'h0000;
		repeat (4) @(posedge i_clk);
		i_rst <= 1'b0;
		s_regs();
		s_analog();
		wr(REG_CTRL, 8'h00);
		s_seq(8'h05, 8'h02, 8'h01, 1);
		s_seq(8'h05, 8'h00, 8'h00, 1);
		s_seq(8'h05, 8'h00, 8'h04, 1);
		s_seq(8'h05, 8'h03, 8'h00, 1);
		s_seq(8'h05, 8'hFF, 8'hFF, 1);
		wr(REG_CTRL, 8'h01);
		s_seq(8'h01, 8'h03, 8'h02, 4);
		s_seq(8'h00, 8'h01, 8'h00, 2);
		s_seq(8'h3F, 8'h01, 8'h01, 128);
		wr(REG_CTRL, 8'h00);
		s_count();
		s_thresh();
		s_filter();
		end_of_test();
	end

	initial begin
		repeat (40000) @(posedge i_clk);
		mismatches++;
		end_of_test();
	end
endmodule : tb
